// File: core/sysref_ctrl_consts.svh
// Register offsets, field positions, reset values and timing figures of the SYSREF control bank
`ifndef SYSREF_CTRL_CONSTS_SVH
`define SYSREF_CTRL_CONSTS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define ADDR_GLOBAL_DELAY 7'h00
`define ADDR_CHANGE_KEY 7'h01
`define ADDR_SYSREF_CTRL 7'h02
`define ADDR_PULSE_COUNT 7'h03
`define ADDR_VCXO_CFG 7'h04
`define ADDR_STATUS 7'h05

// ****************************************************************
// Field positions
// ****************************************************************
`define BIT_SOURCE_SELECT 0
`define BIT_GEN_SOURCE 1
`define BIT_PULSE_MODE 2
`define BIT_MASK_VCXO_UNLOCK 3
`define BIT_SERIAL_WIRE_MODE 4
`define BIT_SERIAL_PIN_VSEL 5
`define BIT_STATUS_PIN_VSEL 6
`define BIT_TRIGGER 7
`define BIT_VCXO_POWERDOWN_N 7
`define BIT_VCXO_STYLE 6
`define BIT_VCXO_AMP_HI 1
`define BIT_VCXO_AMP_LO 0
`define BIT_ST_LOCK 0
`define BIT_ST_BUSY 1
`define BIT_ST_KEY_OK 2
`define BIT_ST_VCXO_UNLOCK 3

// ****************************************************************
// Reset values and constants
// ****************************************************************
`define RST_GLOBAL_DELAY 8'h00
`define RST_CHANGE_KEY 8'h00
`define RST_SYSREF_CTRL 8'h00
`define RST_PULSE_COUNT 8'h02
`define CHANGE_KEY_VALUE 8'h4B
`define VCXO_STARTUP_POWERDOWN_N 1'b1
`define VCXO_STARTUP_STYLE 1'b0
`define VCXO_STARTUP_AMPLITUDE 2'h0
`define DELAY_STEP_PS 17'h0_01FD
`define SYSREF_HALF_CYCLES 8

`endif

// File: core/sysref_ctrl_pkg.sv
// Types shared by the SYSREF control bank
package sysref_ctrl_pkg;
  typedef enum logic [1:0] {GEN_IDLE, GEN_HIGH, GEN_LOW} gen_state_type;
endpackage

// File: core/spi_serial_port.sv
// Serial configuration port with 3-wire or 4-wire read-back
`timescale 1ns/1ps
module spi_serial_port #(
  parameter int ADDR_W = 7,
  parameter int DATA_W = 8
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic serial_data_pin_in,
  input wire logic wire_mode,
  input wire logic [DATA_W-1:0] rd_data,
  output logic [ADDR_W-1:0] addr_reg,
  output logic [DATA_W-1:0] wr_data_reg,
  output logic wr_en_reg,
  output logic serial_data_pin_out_reg,
  output logic serial_data_pin_oe_reg,
  output logic sdo_out_reg,
  output logic sdo_oe_reg
);
  localparam int HDR = 1 + ADDR_W;
  localparam int FRAME = HDR + DATA_W;
  localparam int CW = $clog2(FRAME + 1);
  localparam logic [CW-1:0] HDR_C = CW'(HDR);
  localparam logic [CW-1:0] LAST_C = CW'(FRAME - 1);
  localparam logic [CW-1:0] FRAME_C = CW'(FRAME);

  if (ADDR_W < 2 || DATA_W < 2) begin : g_bad_width
    $error("spi_serial_port: widths too small");
  end

  logic sclk_reg;
  logic [CW-1:0] cnt_reg;
  logic [FRAME-1:0] in_shift_reg;
  logic [DATA_W-1:0] out_shift_reg;
  logic read_reg;
  logic load_reg;
  logic rise;
  logic fall;
  logic data_phase;

  assign rise = sclk & ~sclk_reg & ~cs_n;
  assign fall = ~sclk & sclk_reg & ~cs_n;
  assign data_phase = read_reg && cnt_reg >= HDR_C && cnt_reg < FRAME_C;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_reg <= 1'b0;
      cnt_reg <= '0;
      in_shift_reg <= '0;
    end else begin
      sclk_reg <= sclk;
      if (cs_n) begin
        cnt_reg <= '0;
      end else if (rise && cnt_reg != FRAME_C) begin
        cnt_reg <= cnt_reg + 1'b1;
        in_shift_reg <= {in_shift_reg[FRAME-2:0], serial_data_pin_in};
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      read_reg <= 1'b0;
      load_reg <= 1'b0;
      addr_reg <= '0;
      wr_en_reg <= 1'b0;
      wr_data_reg <= '0;
    end else begin
      load_reg <= 1'b0;
      wr_en_reg <= 1'b0;
      if (cs_n) begin
        read_reg <= 1'b0;
      end else if (rise && cnt_reg == HDR_C - 1'b1) begin
        read_reg <= in_shift_reg[HDR-2];
        load_reg <= in_shift_reg[HDR-2];
        addr_reg <= {in_shift_reg[ADDR_W-2:0], serial_data_pin_in};
      end else if (rise && cnt_reg == LAST_C && !read_reg) begin
        wr_en_reg <= 1'b1;
        wr_data_reg <= {in_shift_reg[DATA_W-2:0], serial_data_pin_in};
      end
    end
  end

  // Read data leaves on falling SCLK; pin choice follows the wire mode
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      out_shift_reg <= '0;
      serial_data_pin_out_reg <= 1'b0;
      serial_data_pin_oe_reg <= 1'b0;
      sdo_out_reg <= 1'b0;
      sdo_oe_reg <= 1'b0;
    end else if (cs_n) begin
      serial_data_pin_oe_reg <= 1'b0;
      sdo_oe_reg <= 1'b0;
    end else if (load_reg) begin
      out_shift_reg <= rd_data;
    end else if (fall && data_phase) begin
      out_shift_reg <= {out_shift_reg[DATA_W-2:0], 1'b0};
      serial_data_pin_out_reg <= out_shift_reg[DATA_W-1];
      sdo_out_reg <= out_shift_reg[DATA_W-1];
      serial_data_pin_oe_reg <= ~wire_mode;
      sdo_oe_reg <= wire_mode;
    end
  end
endmodule // spi_serial_port

// File: core/sysref_pulse_gen.sv
// Counted or continuous SYSREF pulse generator
`timescale 1ns/1ps
`include "sysref_ctrl_consts.svh"
module sysref_pulse_gen
  import sysref_ctrl_pkg::*;
#(
  parameter int HALF_CYCLES = `SYSREF_HALF_CYCLES
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic start,
  input wire logic abort,
  input wire logic continuous,
  input wire logic [7:0] count,
  output logic pulse_reg,
  output logic busy_reg
);
  localparam int TW = $clog2(HALF_CYCLES + 1);
  localparam logic [TW-1:0] RELOAD = TW'(HALF_CYCLES - 1);

  if (HALF_CYCLES < 1) begin : g_bad_half
    $error("sysref_pulse_gen: HALF_CYCLES below one");
  end

  gen_state_type state_reg;
  logic [TW-1:0] timer_reg;
  logic [7:0] left_reg;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= GEN_IDLE;
      timer_reg <= '0;
      left_reg <= 8'h00;
    end else if (abort) begin
      state_reg <= GEN_IDLE;
    end else if (start) begin
      // A new trigger restarts the sequence
      timer_reg <= RELOAD;
      left_reg <= continuous ? 8'h00 : count;
      state_reg <= (continuous || count != 8'h00) ? GEN_HIGH : GEN_IDLE;
    end else begin
      timer_reg <= (timer_reg == '0) ? RELOAD : timer_reg - 1'b1;
      case (state_reg)
        GEN_HIGH: begin
          if (timer_reg == '0) begin
            state_reg <= GEN_LOW;
            if (left_reg != 8'h00) begin
              left_reg <= left_reg - 8'h01;
            end
          end
        end
        GEN_LOW: begin
          if (timer_reg == '0) begin
            state_reg <= (continuous || left_reg != 8'h00) ? GEN_HIGH : GEN_IDLE;
          end
        end
        default: begin
          state_reg <= GEN_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pulse_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      pulse_reg <= (state_reg == GEN_HIGH);
      busy_reg <= (state_reg != GEN_IDLE);
    end
  end
endmodule // sysref_pulse_gen

// File: core/sysref_ctrl.sv
// SYSREF and VCXO output control register bank behind the serial port
//
// Function
// - SYSREF outputs are delayed by the global code times 509 ps.
// - Host writes key 0x4B after VCXO output bits to apply them.
// - Without the key, VCXO output bit changes take no effect.
// - Without the key, VCXO output runs LVPECL, 750 mV, powered on.
// - Source select 0 takes the external pin, 1 the third clock input.
// - Generation bit 0 means internal trigger control, 1 the source picked by source select.
// - Pulse mode 0 gives a counted burst, 1 gives continuous pulses.
// - Mask bit 1 keeps VCXO-PLL lock out of the lock pin.
// - Wire mode 0: data pin is bidirectional, serial out pin floats.
// - Wire mode 1: data pin is input only, reads go on serial out.
// - Trigger powers up SYSREF and releases pulses by the pulse count.
// - Trigger acts only while internal generation is selected.
// - Trigger aligns SYSREF outputs to clocks and applies the delay.
`timescale 1ns/1ps
`include "sysref_ctrl_consts.svh"
module sysref_ctrl
  import sysref_ctrl_pkg::*;
#(
  parameter int HALF_CYCLES = `SYSREF_HALF_CYCLES
) (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic SERIAL_DATA_PIN_IN,
  output logic SERIAL_DATA_PIN_OUT,
  output logic SERIAL_DATA_PIN_OE,
  output logic SDO_OUT,
  output logic SDO_OE,
  input wire logic EXT_SYSREF,
  input wire logic CLK3_SYSREF,
  input wire logic RF_PLL_LOCKED,
  input wire logic VCXO_PLL_UNLOCK,
  output logic LOCK,
  output logic SYSREF_OUT,
  output logic SYSREF_POWER_UP,
  output logic SYSREF_ALIGN,
  output logic [7:0] SYSREF_DELAY_CODE,
  output logic [16:0] SYSREF_DELAY_PS,
  output logic VCXO_OUTPUT_POWERDOWN_N,
  output logic VCXO_OUTPUT_STYLE,
  output logic [1:0] VCXO_OUTPUT_AMPLITUDE,
  output logic SERIAL_PIN_VOLTAGE_SELECT,
  output logic STATUS_PIN_VOLTAGE_SELECT
);

  if (HALF_CYCLES < 1) begin : g_bad_half
    $error("sysref_ctrl: HALF_CYCLES below one");
  end

  // ****************************************************************
  // Register storage
  // ****************************************************************
  logic [7:0] global_sysref_delay_reg;
  logic [7:0] vcxo_output_change_key_reg;
  logic [7:0] ctrl_reg;
  logic [7:0] sysref_pulse_count_reg;
  logic [7:0] vcxo_cfg_reg;
  logic [6:0] addr;
  logic [7:0] wr_data;
  logic wr_en;
  logic [7:0] rd_data;
  logic sysref_source_select;
  logic sysref_gen_source;
  logic sysref_pulse_mode;
  logic mask_vcxo_unlock_to_pin;
  logic serial_wire_mode;
  logic key_ok;
  logic trigger;
  logic trigger_reg;
  logic gen_pulse;
  logic gen_busy;
  logic selected_sysref;
  logic [16:0] delay_ps_next;

  assign sysref_source_select = ctrl_reg[`BIT_SOURCE_SELECT];
  assign sysref_gen_source = ctrl_reg[`BIT_GEN_SOURCE];
  assign sysref_pulse_mode = ctrl_reg[`BIT_PULSE_MODE];
  assign mask_vcxo_unlock_to_pin = ctrl_reg[`BIT_MASK_VCXO_UNLOCK];
  assign serial_wire_mode = ctrl_reg[`BIT_SERIAL_WIRE_MODE];
  assign key_ok = (vcxo_output_change_key_reg == `CHANGE_KEY_VALUE);

  // ****************************************************************
  // Serial configuration port
  // ****************************************************************
  spi_serial_port #(
    .ADDR_W(7),
    .DATA_W(8)
  ) u_port (
    .clk(CLK),
    .arst_n(ARST_N),
    .sclk(SCLK),
    .cs_n(CS_N),
    .serial_data_pin_in(SERIAL_DATA_PIN_IN),
    .wire_mode(serial_wire_mode),
    .rd_data(rd_data),
    .addr_reg(addr),
    .wr_data_reg(wr_data),
    .wr_en_reg(wr_en),
    .serial_data_pin_out_reg(SERIAL_DATA_PIN_OUT),
    .serial_data_pin_oe_reg(SERIAL_DATA_PIN_OE),
    .sdo_out_reg(SDO_OUT),
    .sdo_oe_reg(SDO_OE)
  );

  // ****************************************************************
  // Register writes
  // ****************************************************************
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      global_sysref_delay_reg <= `RST_GLOBAL_DELAY;
      vcxo_output_change_key_reg <= `RST_CHANGE_KEY;
      ctrl_reg <= `RST_SYSREF_CTRL;
      sysref_pulse_count_reg <= `RST_PULSE_COUNT;
    end else if (wr_en) begin
      if (addr == `ADDR_GLOBAL_DELAY) begin
        global_sysref_delay_reg <= wr_data;
      end else if (addr == `ADDR_CHANGE_KEY) begin
        vcxo_output_change_key_reg <= wr_data;
      end else if (addr == `ADDR_SYSREF_CTRL) begin
        // The trigger bit is never stored
        ctrl_reg <= {1'b0, wr_data[`BIT_STATUS_PIN_VSEL:0]};
      end else if (addr == `ADDR_PULSE_COUNT) begin
        sysref_pulse_count_reg <= wr_data;
      end
    end
  end

  // Staged VCXO output bits are always writable; the key decides their effect
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      vcxo_cfg_reg <= {`VCXO_STARTUP_POWERDOWN_N, `VCXO_STARTUP_STYLE, 4'h0,
                       `VCXO_STARTUP_AMPLITUDE};
    end else if (wr_en && addr == `ADDR_VCXO_CFG) begin
      vcxo_cfg_reg <= wr_data;
    end
  end

  // ****************************************************************
  // Register reads
  // ****************************************************************
  always_comb begin
    rd_data = 8'h00;
    if (addr == `ADDR_GLOBAL_DELAY) begin
      rd_data = global_sysref_delay_reg;
    end else if (addr == `ADDR_CHANGE_KEY) begin
      rd_data = vcxo_output_change_key_reg;
    end else if (addr == `ADDR_SYSREF_CTRL) begin
      rd_data = ctrl_reg;
    end else if (addr == `ADDR_PULSE_COUNT) begin
      rd_data = sysref_pulse_count_reg;
    end else if (addr == `ADDR_VCXO_CFG) begin
      rd_data = vcxo_cfg_reg;
    end else if (addr == `ADDR_STATUS) begin
      rd_data[`BIT_ST_LOCK] = LOCK;
      rd_data[`BIT_ST_BUSY] = gen_busy;
      rd_data[`BIT_ST_KEY_OK] = key_ok;
      rd_data[`BIT_ST_VCXO_UNLOCK] = VCXO_PLL_UNLOCK;
    end
  end

  // ****************************************************************
  // Trigger
  // ****************************************************************
  // Honoured only under internal generation, as a single-cycle strobe
  assign trigger = wr_en && addr == `ADDR_SYSREF_CTRL && wr_data[`BIT_TRIGGER]
                   && !wr_data[`BIT_GEN_SOURCE];

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      trigger_reg <= 1'b0;
    end else begin
      trigger_reg <= trigger;
    end
  end

  sysref_pulse_gen #(
    .HALF_CYCLES(HALF_CYCLES)
  ) u_gen (
    .clk(CLK),
    .arst_n(ARST_N),
    .start(trigger_reg),
    .abort(sysref_gen_source),
    .continuous(sysref_pulse_mode),
    .count(sysref_pulse_count_reg),
    .pulse_reg(gen_pulse),
    .busy_reg(gen_busy)
  );

  // ****************************************************************
  // SYSREF path
  // ****************************************************************
  assign selected_sysref = sysref_source_select ? CLK3_SYSREF : EXT_SYSREF;
  assign delay_ps_next = 17'(global_sysref_delay_reg) * `DELAY_STEP_PS;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      SYSREF_OUT <= 1'b0;
      SYSREF_POWER_UP <= 1'b0;
    end else begin
      SYSREF_OUT <= sysref_gen_source ? selected_sysref : gen_pulse;
      SYSREF_POWER_UP <= trigger_reg || gen_busy || sysref_gen_source;
    end
  end

  // Alignment strobe and delay hand-over to the output paths
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      SYSREF_ALIGN <= 1'b0;
      SYSREF_DELAY_CODE <= `RST_GLOBAL_DELAY;
      SYSREF_DELAY_PS <= 17'h0_0000;
    end else begin
      SYSREF_ALIGN <= trigger;
      if (trigger) begin
        SYSREF_DELAY_CODE <= global_sysref_delay_reg;
        SYSREF_DELAY_PS <= delay_ps_next;
      end
    end
  end

  // ****************************************************************
  // VCXO clock output
  // ****************************************************************
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      VCXO_OUTPUT_POWERDOWN_N <= `VCXO_STARTUP_POWERDOWN_N;
      VCXO_OUTPUT_STYLE <= `VCXO_STARTUP_STYLE;
      VCXO_OUTPUT_AMPLITUDE <= `VCXO_STARTUP_AMPLITUDE;
    end else if (key_ok) begin
      VCXO_OUTPUT_POWERDOWN_N <= vcxo_cfg_reg[`BIT_VCXO_POWERDOWN_N];
      VCXO_OUTPUT_STYLE <= vcxo_cfg_reg[`BIT_VCXO_STYLE];
      VCXO_OUTPUT_AMPLITUDE <= vcxo_cfg_reg[`BIT_VCXO_AMP_HI:`BIT_VCXO_AMP_LO];
    end else begin
      VCXO_OUTPUT_POWERDOWN_N <= `VCXO_STARTUP_POWERDOWN_N;
      VCXO_OUTPUT_STYLE <= `VCXO_STARTUP_STYLE;
      VCXO_OUTPUT_AMPLITUDE <= `VCXO_STARTUP_AMPLITUDE;
    end
  end

  // ****************************************************************
  // Lock pin and pin voltage selects
  // ****************************************************************
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      LOCK <= 1'b0;
      SERIAL_PIN_VOLTAGE_SELECT <= 1'b0;
      STATUS_PIN_VOLTAGE_SELECT <= 1'b0;
    end else begin
      LOCK <= RF_PLL_LOCKED && (mask_vcxo_unlock_to_pin || !VCXO_PLL_UNLOCK);
      SERIAL_PIN_VOLTAGE_SELECT <= ctrl_reg[`BIT_SERIAL_PIN_VSEL];
      STATUS_PIN_VOLTAGE_SELECT <= ctrl_reg[`BIT_STATUS_PIN_VSEL];
    end
  end

endmodule // sysref_ctrl

// File: tb/sysref_ctrl_props.sv
// Checker for the SYSREF control bank ports
`timescale 1ns/1ps
module sysref_ctrl_props
  import sysref_ctrl_pkg::*;
#(
  parameter int HALF_CYCLES = 8
) (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic CS_N,
  input wire logic SERIAL_DATA_PIN_OE,
  input wire logic SDO_OE,
  input wire logic RF_PLL_LOCKED,
  input wire logic VCXO_PLL_UNLOCK,
  input wire logic LOCK,
  input wire logic SYSREF_OUT,
  input wire logic SYSREF_POWER_UP,
  input wire logic SYSREF_ALIGN,
  input wire logic [7:0] SYSREF_DELAY_CODE,
  input wire logic [16:0] SYSREF_DELAY_PS
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!ARST_N);

  // ****************
  // Assertions
  // ****************
  a_lock_rf_low: assert property (!RF_PLL_LOCKED |=> !LOCK)
    else $error("lock high without second pll lock");
  a_lock_all_ok: assert property (RF_PLL_LOCKED && !VCXO_PLL_UNLOCK |=> LOCK)
    else $error("lock low with both plls locked");
  a_delay_scale: assert property (SYSREF_DELAY_PS == 17'(SYSREF_DELAY_CODE) * 17'h0_01FD)
    else $error("delay in ps not code times step");
  a_delay_load: assert property ($changed(SYSREF_DELAY_CODE) |-> SYSREF_ALIGN)
    else $error("delay code changed without alignment");
  a_align_single: assert property (SYSREF_ALIGN |=> !SYSREF_ALIGN)
    else $error("alignment pulse longer than one cycle");
  a_align_power: assert property (SYSREF_ALIGN |=> SYSREF_POWER_UP)
    else $error("sysref not powered after trigger");
  a_first_pulse: assert property (SYSREF_ALIGN && !SYSREF_POWER_UP |=> !SYSREF_OUT ##1 !SYSREF_OUT)
    else $error("sysref pulse before alignment settled");
  a_pulse_power: assert property ($rose(SYSREF_OUT) |-> SYSREF_POWER_UP)
    else $error("sysref pulse while powered down");
  a_pin_exclusive: assert property (!(SERIAL_DATA_PIN_OE && SDO_OE))
    else $error("both serial pins driven");
  a_idle_release: assert property (CS_N [*3] |-> !SERIAL_DATA_PIN_OE && !SDO_OE)
    else $error("serial pin driven outside a frame");

  c_align: cover property (SYSREF_ALIGN);
  c_sdo_read: cover property (SDO_OE);
  c_serial_data_pin_read: cover property (SERIAL_DATA_PIN_OE);
  c_lock_fall: cover property ($fell(LOCK));
endmodule // sysref_ctrl_props

bind sysref_ctrl sysref_ctrl_props #(.HALF_CYCLES(HALF_CYCLES)) sysref_ctrl_props_inst (
  .CLK(CLK), .ARST_N(ARST_N), .CS_N(CS_N), .SERIAL_DATA_PIN_OE(SERIAL_DATA_PIN_OE), .SDO_OE(SDO_OE),
  .RF_PLL_LOCKED(RF_PLL_LOCKED), .VCXO_PLL_UNLOCK(VCXO_PLL_UNLOCK), .LOCK(LOCK),
  .SYSREF_OUT(SYSREF_OUT), .SYSREF_POWER_UP(SYSREF_POWER_UP), .SYSREF_ALIGN(SYSREF_ALIGN),
  .SYSREF_DELAY_CODE(SYSREF_DELAY_CODE), .SYSREF_DELAY_PS(SYSREF_DELAY_PS)
);

// File: tb/host_model.sv
// Host model sending serial frames to the SYSREF control bank
`timescale 1ns/1ps
module host_model (
  input wire logic clk,
  input wire logic four_wire,
  input wire logic serial_data_pin_wire,
  input wire logic sdo_wire,
  output logic sclk,
  output logic cs_n,
  output logic serial_data_pin_d,
  output logic serial_data_pin_oe
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    serial_data_pin_d = 1'b0;
    serial_data_pin_oe = 1'b1;
  end

  // ****************
  // Frame: read flag, address, data, MSB first
  // ****************
  task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] wd,
                      output logic [7:0] q);
    logic [15:0] f;
    f = {rd, a, wd};
    q = 8'h00;
    @(posedge clk) cs_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      @(posedge clk) sclk <= 1'b0;
      serial_data_pin_d <= f[i];
      // Data pin handed to the device only for 3-wire read data
      serial_data_pin_oe <= !(rd && i < 8 && !four_wire);
      repeat (2) @(posedge clk);
      @(posedge clk) sclk <= 1'b1;
      if (i < 8) q[i] = four_wire ? sdo_wire : serial_data_pin_wire;
      repeat (2) @(posedge clk);
    end
    @(posedge clk) sclk <= 1'b0;
    repeat (2) @(posedge clk);
    @(posedge clk) cs_n <= 1'b1;
    // Take the data pin back only after the device has let it go
    repeat (3) @(posedge clk);
    serial_data_pin_oe <= 1'b1;
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q;
    xfer(1'b0, a, d, q);
  endtask

  task automatic rd(input logic [6:0] a, output logic [7:0] q);
    xfer(1'b1, a, 8'h00, q);
  endtask
endmodule // host_model

// File: tb/sysref_ctrl_tb_top.sv
// Self-checking bench for the SYSREF control bank
`timescale 1ns/1ps
`include "sysref_ctrl_consts.svh"
module sysref_ctrl_tb_top
  import sysref_ctrl_pkg::*;
;
  logic clk, arst_n, ext_sysref, clk3_sysref, rf_locked, vcxo_unlock, four_wire;
  logic sclk, cs_n, h_d, h_oe, serial_data_pin_out, serial_data_pin_oe, sdo_out, sdo_oe, lock;
  logic sysref_out, power_up, align, vpd_n, vstyle, prev_out, svsel, stvsel;
  logic [1:0] vamp;
  logic [7:0] delay_code;
  logic [16:0] delay_ps;
  wire logic serial_data_pin_wire;
  wire logic sdo_wire;
  wire logic [3:0] vcfg;
  int failures = 0;
  int cmp_count = 0;
  int align_cnt = 0;
  int rise_cnt = 0;
  int sdo_cnt = 0;
  int serial_data_pin_cnt = 0;

  // Released lines show the inverse of their last value
  assign serial_data_pin_wire = serial_data_pin_oe ? serial_data_pin_out : (h_oe ? h_d : ~h_d);
  assign sdo_wire = sdo_oe ? sdo_out : ~sdo_out;
  assign vcfg = {vpd_n, vstyle, vamp};

  sysref_ctrl #(.HALF_CYCLES(2)) sysref_ctrl_inst (
    .CLK(clk), .ARST_N(arst_n), .SCLK(sclk), .CS_N(cs_n), .SERIAL_DATA_PIN_IN(serial_data_pin_wire),
    .SERIAL_DATA_PIN_OUT(serial_data_pin_out), .SERIAL_DATA_PIN_OE(serial_data_pin_oe), .SDO_OUT(sdo_out), .SDO_OE(sdo_oe),
    .EXT_SYSREF(ext_sysref), .CLK3_SYSREF(clk3_sysref), .RF_PLL_LOCKED(rf_locked),
    .VCXO_PLL_UNLOCK(vcxo_unlock), .LOCK(lock), .SYSREF_OUT(sysref_out),
    .SYSREF_POWER_UP(power_up), .SYSREF_ALIGN(align), .SYSREF_DELAY_CODE(delay_code),
    .SYSREF_DELAY_PS(delay_ps), .VCXO_OUTPUT_POWERDOWN_N(vpd_n), .VCXO_OUTPUT_STYLE(vstyle),
    .VCXO_OUTPUT_AMPLITUDE(vamp), .SERIAL_PIN_VOLTAGE_SELECT(svsel),
    .STATUS_PIN_VOLTAGE_SELECT(stvsel)
  );

  host_model host_model_inst (
    .clk(clk), .four_wire(four_wire), .serial_data_pin_wire(serial_data_pin_wire), .sdo_wire(sdo_wire),
    .sclk(sclk), .cs_n(cs_n), .serial_data_pin_d(h_d), .serial_data_pin_oe(h_oe)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Event counters sampled away from the launching edge
  always @(negedge clk) begin
    if (align === 1'b1) align_cnt++;
    if (sysref_out === 1'b1 && prev_out !== 1'b1) rise_cnt++;
    prev_out = sysref_out;
    if (sdo_oe === 1'b1) sdo_cnt++;
    if (serial_data_pin_oe === 1'b1) serial_data_pin_cnt++;
  end

  // ****************
  // Helpers
  // ****************
  task automatic chk(input string nm, input logic [16:0] exp, input logic [16:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic rdchk(input logic [6:0] a, input logic [7:0] exp, input string nm);
    logic [7:0] q;
    host_model_inst.rd(a, q);
    chk(nm, 17'(exp), 17'(q));
  endtask

  task automatic drive(input logic rf, input logic ul, input logic ex, input logic c3);
    @(posedge clk) begin
      rf_locked <= rf;
      vcxo_unlock <= ul;
      ext_sysref <= ex;
      clk3_sysref <= c3;
    end
    repeat (3) @(posedge clk);
  endtask

  task automatic end_sim();
    $display("counts: %0d compared, %0d mismatched", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ****************
  // Scenarios
  // ****************
  task automatic t_reset();
    rdchk(`ADDR_PULSE_COUNT, 8'h02, "pulse count");
    rdchk(`ADDR_CHANGE_KEY, 8'h00, "key");
    rdchk(`ADDR_SYSREF_CTRL, 8'h00, "ctrl");
    rdchk(7'h7F, 8'h00, "unmapped");
    rdchk(`ADDR_STATUS, 8'h01, "status");
    chk("vcxo startup", 17'h0_0008, 17'(vcfg));
    host_model_inst.wr(`ADDR_SYSREF_CTRL, 8'h20);
    chk("serial vsel", 17'h0_0001, 17'({stvsel, svsel}));
    host_model_inst.wr(`ADDR_SYSREF_CTRL, 8'h40);
    chk("status vsel", 17'h0_0002, 17'({stvsel, svsel}));
    $display("test reset done");
  endtask

  task automatic t_vcxo();
    host_model_inst.wr(`ADDR_VCXO_CFG, 8'h43);
    chk("vcxo no key", 17'h0_0008, 17'(vcfg));
    host_model_inst.wr(`ADDR_CHANGE_KEY, 8'h4B);
    chk("vcxo keyed", 17'h0_0007, 17'(vcfg));
    rdchk(`ADDR_STATUS, 8'h05, "status keyed");
    host_model_inst.wr(`ADDR_CHANGE_KEY, 8'h4A);
    chk("vcxo wrong key", 17'h0_0008, 17'(vcfg));
    $display("test vcxo done");
  endtask

  task automatic t_burst();
    logic [7:0] n[3] = '{8'h00, 8'h01, 8'h03};
    logic [7:0] d;
    int a0, r0;
    for (int k = 0; k < 3; k++) begin
      d = 8'hFF - n[k];
      host_model_inst.wr(`ADDR_GLOBAL_DELAY, d);
      host_model_inst.wr(`ADDR_PULSE_COUNT, n[k]);
      a0 = align_cnt;
      r0 = rise_cnt;
      host_model_inst.wr(`ADDR_SYSREF_CTRL, 8'h80);
      repeat (30) @(posedge clk);
      chk("align", 17'h0_0001, 17'(align_cnt - a0));
      chk("pulses", 17'(n[k]), 17'(rise_cnt - r0));
      chk("delay code", 17'(d), 17'(delay_code));
      chk("delay ps", 17'(d) * 17'h0_01FD, delay_ps);
      chk("power up", 17'h0_0000, 17'(power_up));
    end
    rdchk(`ADDR_SYSREF_CTRL, 8'h00, "trigger clear");
    $display("test burst done");
  endtask

  task automatic t_gate();
    int a0;
    a0 = align_cnt;
    host_model_inst.wr(`ADDR_SYSREF_CTRL, 8'h82);
    drive(1'b1, 1'b0, 1'b1, 1'b0);
    chk("ext pin", 17'h0_0001, 17'(sysref_out));
    chk("align gated", 17'h0_0000, 17'(align_cnt - a0));
    host_model_inst.wr(`ADDR_SYSREF_CTRL, 8'h03);
    drive(1'b1, 1'b0, 1'b0, 1'b1);
    chk("clk3 high", 17'h0_0001, 17'(sysref_out));
    drive(1'b1, 1'b0, 1'b1, 1'b0);
    chk("clk3 low", 17'h0_0000, 17'(sysref_out));
    host_model_inst.wr(`ADDR_SYSREF_CTRL, 8'h00);
    $display("test gate done");
  endtask

  task automatic t_cont();
    int r0;
    host_model_inst.wr(`ADDR_PULSE_COUNT, 8'h01);
    host_model_inst.wr(`ADDR_SYSREF_CTRL, 8'h84);
    r0 = rise_cnt;
    repeat (40) @(posedge clk);
    chk("continuous", 17'h0_000A, 17'(rise_cnt - r0));
    host_model_inst.wr(`ADDR_SYSREF_CTRL, 8'h00);
    repeat (10) @(posedge clk);
    r0 = rise_cnt;
    repeat (20) @(posedge clk);
    chk("stopped", 17'h0_0000, 17'(rise_cnt - r0));
    $display("test continuous done");
  endtask

  task automatic t_lock();
    drive(1'b1, 1'b1, 1'b0, 1'b0);
    chk("lock unmasked", 17'h0_0000, 17'(lock));
    host_model_inst.wr(`ADDR_SYSREF_CTRL, 8'h08);
    chk("lock masked", 17'h0_0001, 17'(lock));
    drive(1'b0, 1'b1, 1'b0, 1'b0);
    chk("lock rf low", 17'h0_0000, 17'(lock));
    drive(1'b1, 1'b0, 1'b0, 1'b0);
    host_model_inst.wr(`ADDR_SYSREF_CTRL, 8'h00);
    chk("lock ok", 17'h0_0001, 17'(lock));
    $display("test lock done");
  endtask

  task automatic t_four();
    int o0, s0;
    host_model_inst.wr(`ADDR_PULSE_COUNT, 8'hA5);
    host_model_inst.wr(`ADDR_SYSREF_CTRL, 8'h10);
    @(posedge clk) four_wire <= 1'b1;
    s0 = serial_data_pin_cnt;
    rdchk(`ADDR_PULSE_COUNT, 8'hA5, "four wire read");
    chk("data pin idle", 17'h0_0000, 17'(serial_data_pin_cnt - s0));
    host_model_inst.wr(`ADDR_SYSREF_CTRL, 8'h00);
    @(posedge clk) four_wire <= 1'b0;
    o0 = sdo_cnt;
    rdchk(`ADDR_PULSE_COUNT, 8'hA5, "three wire read");
    chk("serial out idle", 17'h0_0000, 17'(sdo_cnt - o0));
    $display("test wire mode done");
  endtask

  initial begin
    arst_n = 1'b0;
    ext_sysref = 1'b0;
    clk3_sysref = 1'b0;
    rf_locked = 1'b1;
    vcxo_unlock = 1'b0;
    four_wire = 1'b0;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_reset();
    t_vcxo();
    t_burst();
    t_gate();
    t_cont();
    t_lock();
    t_four();
    end_sim();
  end

  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    end_sim();
  end
endmodule // sysref_ctrl_tb_top
